// *** smtm_pkg.sv ***
`default_nettype none
package smtm_pkg;
    // Register indices; byte address is four times the index
    localparam logic [3:0] CTRL_STAT_IDX = 4'h8;
    localparam logic [3:0] SEC_ADDR_IDX = 4'h9;
    localparam logic [3:0] LIMIT_HIGH_IDX = 4'hA;
    localparam logic [3:0] LIMIT_LOW_IDX = 4'hB;
    localparam logic [3:0] EVT_STATUS_IDX = 4'hC;
    localparam logic [3:0] EVT_CLEAR_IDX = 4'hD;
    localparam logic [3:0] EVT_ENABLE_IDX = 4'hE;

    // Control and status field positions
    localparam int SEC_ADDR_EN_BIT = 5;
    localparam int CLK_SEL_BIT = 4;
    localparam int LOW_FLAG_BIT = 3;
    localparam int IDLE_FLAG_BIT = 2;
    localparam int HL_FLAG_BIT = 1;
    localparam int HL_IRQ_EN_BIT = 0;

    // Event status, clear and enable share this layout
    localparam int EVT_LOW_BIT = 0;
    localparam int EVT_IDLE_BIT = 1;
    localparam int EVT_HL_BIT = 2;
    localparam int EVT_W = 3;

    // Reset values
    localparam logic [7:0] CTRL_RESET = 8'h00;
    localparam logic [6:0] SEC_ADDR_RESET = 7'h00;
    localparam logic [7:0] LIMIT_RESET = 8'h00;
    localparam logic [EVT_W-1:0] EVT_RESET = 3'h0;

    // Timebase: slow tick every 64 module clocks
    localparam int PRESCALE_DIV = 64;
    localparam int PRESCALE_W = $clog2(PRESCALE_DIV);
    localparam logic [PRESCALE_W-1:0] PRESCALE_LAST = PRESCALE_W'(PRESCALE_DIV - 1);
    // High timeouts use limit / 512
    localparam int HIGH_DIV = 512;
    localparam int HIGH_SHIFT = $clog2(HIGH_DIV);
endpackage
`default_nettype wire

// *** smtm_monitor.sv ***
// Summary of operation
// RQ1 - The timeout tick is the module clock divided by 64 when clock select is 0, and every clock when it is 1.
// RQ2 - The low-timeout flag sets when the 16-bit limit is nonzero and the clock line stays low until the limit.
// RQ3 - Software clears the low-timeout flag by writing one to its bit; writing zero leaves it alone.
// RQ4 - A zero limit disables low-timeout detection and the flag never sets.
// RQ5 - The bus-idle flag sets when both lines stay high longer than the limit divided by 512 ticks.
// RQ6 - The bus-idle flag is read-only and clears by itself once both lines are no longer high.
// RQ7 - The second high flag sets when clock stays high and data low longer than the limit divided by 512 ticks.
// RQ8 - The second high flag stays set until software writes one to its bit.
// RQ9 - Enable bit 0 gates the interrupt of the clock-high data-low timeout.
// RQ10 - The second address register holds a 7-bit slave address in bits 7 to 1.
// RQ11 - Bit 0 of the second address register is reserved and reads zero.
// RQ12 - The high limit register supplies bits 15 to 8 of the low-timeout limit.
// RQ13 - The low limit register supplies bits 7 to 0 of the low-timeout limit.
// RQ14 - Address matching against the second address happens only while its enable bit is one.
// RQ15 - While idle time is still being measured the bus counts as free.
// RQ16 - Each timeout count restarts whenever its monitored line condition ends.
// RQ17 - The interrupt is asserted while the second high flag and its enable bit are both set.
//
// Our own choice: the APB interface to the registers.
`default_nettype none
module smtm_monitor
    import smtm_pkg::*;
#(
    parameter int ADDR_W = 8
) (
    input wire logic clk,
    input wire logic rst_b,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic sclIn,
    input wire logic sdaIn,
    input wire logic addrValid,
    input wire logic [6:0] addrIn,
    output logic addrMatch,
    output logic busFree,
    output logic irq
);

    // Index decode needs four bits above the byte lanes, plus one upper bit to test for zero
    if (ADDR_W < 7) begin : g_addr_check
        $error("smtm_monitor: ADDR_W must be at least 7");
    end

    // Saturating count, shared by all three timeout counters
    function automatic logic [15:0] sat_inc(input logic [15:0] v);
        sat_inc = (v == 16'hFFFF) ? v : v + 16'h0001;
    endfunction

    logic [2:0] sclQ;
    logic [2:0] sdaQ;
    logic sclS;
    logic sdaS;
    logic [PRESCALE_W-1:0] prescaleReg;
    logic tick;
    logic [15:0] lowCnt;
    logic [15:0] idleCnt;
    logic [15:0] hlCnt;
    logic secAddrEnReg;
    logic clkSelReg;
    logic lowFlagReg;
    logic idleFlagReg;
    logic hlFlagReg;
    logic hlIrqEnReg;
    logic [6:0] secAddrReg;
    logic [7:0] limitHighReg;
    logic [7:0] limitLowReg;
    logic [EVT_W-1:0] evtStatReg;
    logic [EVT_W-1:0] evtEnReg;
    logic [15:0] limitVal;
    logic [15:0] highLimit;
    logic lowHit;
    logic idleHit;
    logic hlHit;
    logic lowSet;
    logic idleSet;
    logic hlSet;
    logic [3:0] regIdx;
    logic aligned;
    logic mapped;
    logic wrDone;
    logic ctrlWr;
    logic evtClrWr;
    logic [7:0] ctrlRead;
    logic [31:0] readMux;

    // Three-stage sampling; only stages two and three are compared
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            sclQ <= 3'h7;
            sdaQ <= 3'h7;
        end else begin
            sclQ <= {sclQ[1:0], sclIn};
            sdaQ <= {sdaQ[1:0], sdaIn};
        end
    end

    // Line level changes only once two stages agree
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            sclS <= 1'b1;
            sdaS <= 1'b1;
        end else begin
            if (sclQ[1] == sclQ[2]) begin
                sclS <= sclQ[2];
            end
            if (sdaQ[1] == sdaQ[2]) begin
                sdaS <= sdaQ[2];
            end
        end
    end

    // Timebase prescaler, free running
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            prescaleReg <= '0;
        end else begin
            prescaleReg <= prescaleReg + PRESCALE_W'(1);
        end
    end

    assign tick = clkSelReg | (prescaleReg == PRESCALE_LAST); // RQ1

    // Limit assembled from the two byte registers
    assign limitVal = {limitHighReg, limitLowReg}; // RQ12 RQ13
    assign highLimit = limitVal >> HIGH_SHIFT;
    assign lowHit = (limitVal != 16'h0000) && (lowCnt >= limitVal); // RQ2 RQ4
    assign idleHit = idleCnt > highLimit; // RQ5
    assign hlHit = hlCnt > highLimit; // RQ7
    assign lowSet = !sclS && lowHit;
    assign idleSet = sclS && sdaS && idleHit;
    assign hlSet = sclS && !sdaS && hlHit;

    // Counters restart as soon as their line condition ends
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            lowCnt <= 16'h0000;
        end else if (sclS) begin
            lowCnt <= 16'h0000; // RQ16
        end else if (tick) begin
            lowCnt <= sat_inc(lowCnt);
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            idleCnt <= 16'h0000;
        end else if (!(sclS && sdaS)) begin
            idleCnt <= 16'h0000; // RQ16
        end else if (tick) begin
            idleCnt <= sat_inc(idleCnt);
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            hlCnt <= 16'h0000;
        end else if (!(sclS && !sdaS)) begin
            hlCnt <= 16'h0000; // RQ16
        end else if (tick) begin
            hlCnt <= sat_inc(hlCnt);
        end
    end

    // APB decode; answer comes one cycle into the access phase
    assign regIdx = paddr[5:2];
    assign aligned = (paddr[1:0] == 2'b00) && (paddr[ADDR_W-1:6] == '0);
    assign mapped = aligned && (regIdx >= CTRL_STAT_IDX) && (regIdx <= EVT_ENABLE_IDX);
    assign wrDone = psel && penable && pready && pwrite && mapped;
    assign ctrlWr = wrDone && (regIdx == CTRL_STAT_IDX);
    assign evtClrWr = wrDone && (regIdx == EVT_CLEAR_IDX);

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= 32'h00000000;
        end else begin
            pready <= psel && penable && !pready;
            pslverr <= psel && penable && !pready && !mapped;
            if (psel && penable && !pready) begin
                prdata <= (!pwrite && mapped) ? readMux : 32'h00000000;
            end
        end
    end

    // Plain control bits and byte registers
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            secAddrEnReg <= CTRL_RESET[SEC_ADDR_EN_BIT];
            clkSelReg <= CTRL_RESET[CLK_SEL_BIT];
            hlIrqEnReg <= CTRL_RESET[HL_IRQ_EN_BIT];
        end else if (ctrlWr) begin
            secAddrEnReg <= pwdata[SEC_ADDR_EN_BIT];
            clkSelReg <= pwdata[CLK_SEL_BIT];
            hlIrqEnReg <= pwdata[HL_IRQ_EN_BIT]; // RQ9
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            secAddrReg <= SEC_ADDR_RESET;
            limitHighReg <= LIMIT_RESET;
            limitLowReg <= LIMIT_RESET;
            evtEnReg <= EVT_RESET;
        end else if (wrDone) begin
            if (regIdx == SEC_ADDR_IDX) begin
                secAddrReg <= pwdata[7:1]; // RQ10
            end
            if (regIdx == LIMIT_HIGH_IDX) begin
                limitHighReg <= pwdata[7:0]; // RQ12
            end
            if (regIdx == LIMIT_LOW_IDX) begin
                limitLowReg <= pwdata[7:0]; // RQ13
            end
            if (regIdx == EVT_ENABLE_IDX) begin
                evtEnReg <= pwdata[EVT_W-1:0];
            end
        end
    end

    // Low flag: write one clears, a new timeout beats the clear
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            lowFlagReg <= 1'b0;
        end else if (lowSet) begin
            lowFlagReg <= 1'b1; // RQ2
        end else if (ctrlWr && pwdata[LOW_FLAG_BIT]) begin
            lowFlagReg <= 1'b0; // RQ3
        end
    end

    // Idle flag follows the line state; software cannot touch it
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            idleFlagReg <= 1'b0;
        end else if (!(sclS && sdaS)) begin
            idleFlagReg <= 1'b0; // RQ6
        end else if (idleSet) begin
            idleFlagReg <= 1'b1; // RQ5
        end
    end

    // Second high flag is sticky until a write of one
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            hlFlagReg <= 1'b0;
        end else if (hlSet) begin
            hlFlagReg <= 1'b1; // RQ7
        end else if (ctrlWr && pwdata[HL_FLAG_BIT]) begin
            hlFlagReg <= 1'b0; // RQ8
        end
    end

    // Sticky event status; a set in the clear cycle survives
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            evtStatReg <= EVT_RESET;
        end else begin
            for (int i = 0; i < EVT_W; i++) begin
                if ((i == EVT_LOW_BIT && lowSet) || (i == EVT_IDLE_BIT && idleSet) ||
                    (i == EVT_HL_BIT && hlSet)) begin
                    evtStatReg[i] <= 1'b1;
                end else if (evtClrWr && pwdata[i]) begin
                    evtStatReg[i] <= 1'b0;
                end
            end
        end
    end

    // Interrupt and line-state outputs, all registered
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            irq <= 1'b0;
            busFree <= 1'b1;
        end else begin
            irq <= (|(evtStatReg & evtEnReg)) || (hlFlagReg && hlIrqEnReg); // RQ9 RQ17
            busFree <= sclS && sdaS; // RQ15
        end
    end

    // Second address compare, gated by its enable
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            addrMatch <= 1'b0;
        end else begin
            addrMatch <= secAddrEnReg && addrValid && (addrIn == secAddrReg); // RQ14
        end
    end

    // Read view; unused bits read as zero
    always_comb begin
        ctrlRead = 8'h00;
        ctrlRead[SEC_ADDR_EN_BIT] = secAddrEnReg;
        ctrlRead[CLK_SEL_BIT] = clkSelReg;
        ctrlRead[LOW_FLAG_BIT] = lowFlagReg;
        ctrlRead[IDLE_FLAG_BIT] = idleFlagReg;
        ctrlRead[HL_FLAG_BIT] = hlFlagReg;
        ctrlRead[HL_IRQ_EN_BIT] = hlIrqEnReg;
        readMux = 32'h00000000;
        case (regIdx)
            CTRL_STAT_IDX: readMux[7:0] = ctrlRead;
            SEC_ADDR_IDX: readMux[7:0] = {secAddrReg, 1'b0}; // RQ11
            LIMIT_HIGH_IDX: readMux[7:0] = limitHighReg;
            LIMIT_LOW_IDX: readMux[7:0] = limitLowReg;
            EVT_STATUS_IDX: readMux[EVT_W-1:0] = evtStatReg;
            EVT_ENABLE_IDX: readMux[EVT_W-1:0] = evtEnReg;
            default: readMux = 32'h00000000;
        endcase
    end

    // Checks
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_b);

    sequence sSlowTick;
        tick && !clkSelReg;
    endsequence

    // A switch to the fast tick may legally follow a slow tick at once
    sequence sNoTickRun;
        (!tick || clkSelReg) [*8];
    endsequence

    sequence sLowClear;
        ctrlWr && pwdata[LOW_FLAG_BIT] && !lowSet;
    endsequence

    a_tick_divided: assert property (sSlowTick ##1 !clkSelReg |-> sNoTickRun) // RQ1
        else $error("slow tick came too early");
    a_tick_fast: assert property (clkSelReg |-> tick) // RQ1
        else $error("fast tick missing");
    a_low_limit_zero: assert property ($rose(lowFlagReg) |-> $past(limitVal) != 16'h0000) // RQ4
        else $error("low flag set with zero limit");
    a_low_flag_set: assert property (!sclS && limitVal != 16'h0000 && lowCnt >= limitVal |=> lowFlagReg) // RQ2
        else $error("low timeout not flagged");
    a_low_flag_hold: assert property (lowFlagReg && !(ctrlWr && pwdata[LOW_FLAG_BIT]) |=> lowFlagReg) // RQ3
        else $error("low flag dropped without clear");
    a_low_flag_clr: assert property (sLowClear |=> !lowFlagReg) // RQ3
        else $error("low flag not cleared");
    a_idle_auto_clr: assert property (!(sclS && sdaS) |=> !idleFlagReg) // RQ6
        else $error("idle flag outlived condition");
    a_idle_set_cause: assert property ($rose(idleFlagReg) |-> $past(sclS && sdaS && idleCnt > highLimit)) // RQ5
        else $error("idle flag without idle time");
    a_hl_sticky: assert property (hlFlagReg && !(ctrlWr && pwdata[HL_FLAG_BIT]) |=> hlFlagReg) // RQ8
        else $error("second high flag dropped");
    a_hl_set_cause: assert property ($rose(hlFlagReg) |-> $past(sclS && !sdaS && hlCnt > highLimit)) // RQ7
        else $error("second high flag without cause");
    a_irq_on_hl: assert property (hlFlagReg && hlIrqEnReg |=> irq) // RQ17
        else $error("interrupt missing");
    a_irq_gated: assert property (!hlIrqEnReg && (evtStatReg & evtEnReg) == '0 |=> !irq) // RQ9
        else $error("interrupt not gated");
    a_low_restart: assert property (sclS |=> lowCnt == 16'h0000) // RQ16
        else $error("low count not restarted");
    a_addr_gate: assert property (addrMatch |-> $past(secAddrEnReg)) // RQ14
        else $error("match with second address off");
    a_addr_bit0: assert property (pready && !pwrite && regIdx == SEC_ADDR_IDX |-> !prdata[0]) // RQ11
        else $error("reserved address bit read one");
    a_bus_free: assert property (sclS && sdaS |=> busFree) // RQ15
        else $error("bus not shown free");

endmodule
`default_nettype wire

// *** smtm_monitor_end.sv ***
`default_nettype none
`default_nettype wire

// *** smtm_bus_peer.sv ***
`default_nettype none
// Other bus parties: open-drain pulls on the two lines
module smtm_bus_peer (
    input wire logic pullScl,
    input wire logic pullSda,
    output logic sclLine,
    output logic sdaLine
);
    timeunit 1ns;
    timeprecision 1ps;
    // Pull-ups make a released line read high, never a stale value
    assign sclLine = ~pullScl;
    assign sdaLine = ~pullSda;
endmodule
`default_nettype wire

// *** smtm_monitor_bench.sv ***
`default_nettype none
module smtm_monitor_bench import smtm_pkg::*;;
    timeunit 1ns;
    timeprecision 1ps;
    localparam logic [7:0] CTL = {2'b00, CTRL_STAT_IDX, 2'b00};
    localparam logic [7:0] SEC = {2'b00, SEC_ADDR_IDX, 2'b00};
    localparam logic [7:0] LHI = {2'b00, LIMIT_HIGH_IDX, 2'b00};
    localparam logic [7:0] LLO = {2'b00, LIMIT_LOW_IDX, 2'b00};
    localparam logic [7:0] EST = {2'b00, EVT_STATUS_IDX, 2'b00};
    localparam logic [7:0] ECL = {2'b00, EVT_CLEAR_IDX, 2'b00};
    localparam logic [7:0] EEN = {2'b00, EVT_ENABLE_IDX, 2'b00};
    logic clk = 1'b0;
    logic rstB = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic pready, pslverr, sclIn, sdaIn, addrMatch, busFree, irq;
    logic pullScl = 1'b0;
    logic pullSda = 1'b0;
    logic addrValid = 1'b0;
    logic [6:0] addrIn = 7'h00;
    logic [31:0] rv, rd;
    logic er;
    int errorCnt = 0;
    int checked = 0;
    integer seed = 32'hADB3;

    smtm_monitor #(.ADDR_W(8)) uut (.clk(clk), .rst_b(rstB), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .sclIn(sclIn),
        .sdaIn(sdaIn), .addrValid(addrValid), .addrIn(addrIn), .addrMatch(addrMatch), .busFree(busFree), .irq(irq));
    smtm_bus_peer peer (.pullScl(pullScl), .pullSda(pullSda), .sclLine(sclIn), .sdaLine(sdaIn));

    // 200 MHz module clock
    initial begin
        forever #2.5 clk = ~clk;
    end

    task automatic stop_test;
        if (errorCnt == 0 && checked > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask

    task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
        checked++;
        if (got !== exp) begin
            errorCnt++;
            $display("BAD %s expected %h seen %h", name, exp, got);
        end
    endtask

    // One APB transfer; waits for pready, bounded
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        do begin
            @(posedge clk);
            n++;
        end while (pready !== 1'b1 && n < 16);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        if (pready !== 1'b1) begin
            errorCnt++;
            stop_test();
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask

    task automatic rdv(input logic [7:0] a, input logic [31:0] exp, input string name);
        apb(1'b0, a, 32'h0);
        chk(name, exp, rd);
    endtask

    // Single-bit read check, other flags may move meanwhile
    task automatic rdb(input logic [7:0] a, input int b, input logic exp, input string name);
        apb(1'b0, a, 32'h0);
        chk(name, {31'h0, exp}, {31'h0, rd[b]});
    endtask

    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
    endtask

    // Match result shows one cycle after the strobe
    task automatic strobe(input logic [6:0] a, input logic exp);
        @(posedge clk);
        addrValid <= 1'b1;
        addrIn <= a;
        @(posedge clk);
        addrValid <= 1'b0;
        @(posedge clk);
        chk("addrMatch", {31'h0, exp}, {31'h0, addrMatch});
    endtask

    function automatic logic [31:0] expSec(input logic [31:0] v);
        return {24'h0, v[7:1], 1'b0};
    endfunction

    // Main sequence
    initial begin
        repeat (2) @(posedge clk);
        rstB <= 1'b1;
        apb(1'b0, CTL, 32'h0);
        chk("ctrl", 32'h0, rd & 32'hFFFF_FFFB);
        rdv(SEC, 32'h0, "secAddr");
        rdv(LHI, 32'h0, "limHigh");
        rdv(LLO, 32'h0, "limLow");
        rdv(EEN, 32'h0, "evtEn");
        rdv(8'h3C, 32'h0, "unmapped");
        chk("pslverr", 32'h1, {31'h0, er});
        // Second address and its enable
        rv = $random(seed);
        wr(SEC, rv);
        rdv(SEC, expSec(rv), "secAddr");
        strobe(rv[7:1], 1'b0);
        wr(CTL, 32'h20);
        strobe(rv[7:1], 1'b1);
        strobe(rv[7:1] ^ 7'h01, 1'b0);
        rv = $random(seed);
        wr(LHI, rv);
        wr(LLO, rv >> 8);
        rdv(LHI, {24'h0, rv[7:0]}, "limHigh");
        rdv(LLO, {24'h0, rv[15:8]}, "limLow");
        // Low timeout, fast tick, limit 8, interrupted low first
        wr(CTL, 32'h10);
        wr(LHI, 32'h0);
        wr(LLO, 32'h8);
        pullScl <= 1'b1;
        cyc(4);
        pullScl <= 1'b0;
        cyc(4);
        pullScl <= 1'b1;
        cyc(4);
        rdb(CTL, LOW_FLAG_BIT, 1'b0, "lowFlag");
        cyc(20);
        rdb(CTL, LOW_FLAG_BIT, 1'b1, "lowFlag");
        rdb(EST, EVT_LOW_BIT, 1'b1, "evtLow");
        pullScl <= 1'b0;
        chk("irq", 32'h0, {31'h0, irq});
        wr(EEN, 32'h1);
        cyc(2);
        chk("irq", 32'h1, {31'h0, irq});
        wr(CTL, 32'h10);
        rdb(CTL, LOW_FLAG_BIT, 1'b1, "lowFlag");
        wr(CTL, 32'h18);
        rdb(CTL, LOW_FLAG_BIT, 1'b0, "lowFlag");
        wr(ECL, 32'h1);
        rdb(EST, EVT_LOW_BIT, 1'b0, "evtLow");
        cyc(2);
        chk("irq", 32'h0, {31'h0, irq});
        wr(EEN, 32'h0);
        // Zero limit never flags
        wr(LLO, 32'h0);
        pullScl <= 1'b1;
        cyc(40);
        rdb(CTL, LOW_FLAG_BIT, 1'b0, "lowFlag");
        rdb(EST, EVT_LOW_BIT, 1'b0, "evtLow");
        pullScl <= 1'b0;
        // Slow tick: limit 2 needs two ticks of 64 clocks
        wr(CTL, 32'h00);
        wr(LLO, 32'h2);
        pullScl <= 1'b1;
        cyc(40);
        rdb(CTL, LOW_FLAG_BIT, 1'b0, "lowFlag");
        cyc(100);
        rdb(CTL, LOW_FLAG_BIT, 1'b1, "lowFlag");
        pullScl <= 1'b0;
        // Let the sampled line go high first, or the still-running timeout wins over the clear
        cyc(4);
        wr(CTL, 32'h18);
        rdb(CTL, LOW_FLAG_BIT, 1'b0, "lowFlag");
        // High timeouts: limit 0x1000 gives 8 ticks
        wr(LLO, 32'h0);
        wr(LHI, 32'h10);
        pullSda <= 1'b1;
        cyc(1);
        rdb(CTL, HL_FLAG_BIT, 1'b0, "hlFlag");
        cyc(1);
        chk("busFree", 32'h0, {31'h0, busFree});
        cyc(12);
        rdb(CTL, HL_FLAG_BIT, 1'b1, "hlFlag");
        chk("irq", 32'h0, {31'h0, irq});
        wr(CTL, 32'h11);
        cyc(2);
        chk("irq", 32'h1, {31'h0, irq});
        pullSda <= 1'b0;
        cyc(14);
        rdb(CTL, HL_FLAG_BIT, 1'b1, "hlFlag");
        chk("busFree", 32'h1, {31'h0, busFree});
        rdb(CTL, IDLE_FLAG_BIT, 1'b1, "idleFlag");
        wr(CTL, 32'h15);
        rdb(CTL, IDLE_FLAG_BIT, 1'b1, "idleFlag");
        pullScl <= 1'b1;
        cyc(5);
        rdb(CTL, IDLE_FLAG_BIT, 1'b0, "idleFlag");
        pullScl <= 1'b0;
        cyc(1);
        rdb(CTL, IDLE_FLAG_BIT, 1'b0, "idleFlag");
        wr(CTL, 32'h13);
        rdb(CTL, HL_FLAG_BIT, 1'b0, "hlFlag");
        cyc(2);
        chk("irq", 32'h0, {31'h0, irq});
        stop_test();
    end
endmodule
`default_nettype wire
